//--- hdl/nbpu_host.v
// host controller for nand block protection and array mode
`timescale 1ns/1ps
`include "nbpu_host_regs.vh"
// Operation
// - every array mode write drives bit 3 as one
// - protection enable held high during every volatile command
// - unlock lower then unlock upper define the unprotected range
// - unlock address is three cycles with block bits spread
// - write protect and protection enable high before lockdown
// - permanent sequence: entry, 80h, five addresses, 10h, poll, ffh
// - at most sixteen permanent sequences in total
// - no reset while a permanent program is busy
// - status read takes three address cycles and returns one byte
module nbpu_host (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // user orders: 0 set mode, 1 unlock, 2 lock all, 3 lockdown,
  // 4 permanent protect, 5 status read, 6 reset
  input  wire        op_valid,
  output wire        op_ready,
  input  wire [2:0]  op_code,
  input  wire [11:0] op_lower_block,
  input  wire [11:0] op_upper_block,
  input  wire        op_invert,
  input  wire [3:0]  op_group,
  input  wire        op_group_lockdown,
  input  wire        op_otp_mode,
  input  wire        op_otp_lock,
  input  wire        op_ecc_sel,
  output reg         done_reg,
  output reg         refused_reg,
  output reg  [7:0]  result_reg,
  output reg  [4:0]  pbp_count_reg,
  // nand pins
  output wire        cle,
  output wire        ale,
  output wire        ce_n,
  output wire        we_n,
  output wire        re_n,
  output wire        wp_n,
  output wire        protection_enable_input,
  output wire [7:0]  io_out,
  output wire        io_oe,
  input  wire [7:0]  io_in,
  input  wire        ready_busy_output
);
  localparam S_IDLE = 2'd0;
  localparam S_RUN  = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam S_POLL = 2'd3;

  reg  [1:0]  state_reg;
  reg  [4:0]  step_reg;
  reg  [4:0]  last_reg;
  reg  [2:0]  code_reg;
  reg  [11:0] lo_reg;
  reg  [11:0] hi_reg;
  reg         inv_reg;
  reg  [7:0]  mode_reg;
  reg  [3:0]  grp_reg;
  reg         grp_ld_reg;
  reg         vld_reg;
  reg         pld_reg;
  reg         rb_s1_reg;
  reg         rb_s2_reg;
  reg         started_reg;
  reg  [1:0]  kind;
  reg  [7:0]  wdata;
  wire        cyc_done;
  wire [7:0]  cyc_rdata;

  // byte cycles of the unlock and status read address
  function [7:0] blk_addr;
    input [11:0] b;
    input [1:0]  idx;
    input        inv;
    begin
      case (idx)
        2'd0:    blk_addr = {b[1:0], 5'h00, inv};
        2'd1:    blk_addr = b[9:2];
        default: blk_addr = {6'h00, b[11:10]};
      endcase
    end
  endfunction

  assign op_ready = (state_reg == S_IDLE);
  assign ce_n = 1'b0;
  assign wp_n = 1'b1;
  assign protection_enable_input = 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // step table: kind and byte for each step of the current order
  always @* begin
    kind  = 2'd0;
    wdata = 8'h00;
    case (code_reg)
      3'd0: begin
        case (step_reg)
          5'd0: wdata = `NBPU_CMD_SET_FEAT;
          5'd1: begin kind = 2'd1; wdata = `NBPU_FEAT_ARRAY_MODE; end
          5'd2: begin kind = 2'd2; wdata = mode_reg; end
          default: begin kind = 2'd2; wdata = 8'h00; end
        endcase
      end
      3'd1: begin
        case (step_reg)
          5'd0: wdata = `NBPU_CMD_UNLOCK_LO;
          5'd1, 5'd2, 5'd3: begin
            kind  = 2'd1;
            wdata = blk_addr(lo_reg, step_reg[1:0] - 2'd1, 1'b0);
          end
          5'd4: wdata = `NBPU_CMD_UNLOCK_HI;
          default: begin
            kind  = 2'd1;
            wdata = blk_addr(hi_reg, step_reg[1:0] - 2'd1, inv_reg);
          end
        endcase
      end
      3'd2: wdata = `NBPU_CMD_LOCK_ALL;
      3'd3: wdata = `NBPU_CMD_LOCKDOWN;
      3'd4: begin
        case (step_reg)
          5'd0: wdata = `NBPU_ENTRY0;
          5'd1: wdata = `NBPU_ENTRY1;
          5'd2: wdata = `NBPU_ENTRY2;
          5'd3: wdata = `NBPU_ENTRY3;
          5'd4: wdata = `NBPU_CMD_PGM_SETUP;
          5'd8: begin
            kind  = 2'd1;
            wdata = {3'h0, grp_ld_reg, grp_reg};
          end
          5'd5, 5'd6, 5'd7, 5'd9: kind = 2'd1;
          5'd10: wdata = `NBPU_CMD_PGM_CONF;
          5'd11: wdata = `NBPU_CMD_STATUS;
          5'd12: kind = 2'd3;
          default: wdata = `NBPU_CMD_RESET;
        endcase
      end
      3'd5: begin
        case (step_reg)
          5'd0: wdata = `NBPU_CMD_PROT_READ;
          5'd1, 5'd2, 5'd3: begin
            kind  = 2'd1;
            wdata = blk_addr(lo_reg, step_reg[1:0] - 2'd1, 1'b0);
          end
          default: kind = 2'd3;
        endcase
      end
      default: wdata = `NBPU_CMD_RESET;
    endcase
  end

  nbpu_bus_cycle u_cycle (
    .clk       (clk),
    .rst       (rst),
    .start     (state_reg == S_RUN),
    .kind      (kind),
    .wdata     (wdata),
    .done      (cyc_done),
    .rdata_reg (cyc_rdata),
    .cle       (cle),
    .ale       (ale),
    .we_n      (we_n),
    .re_n      (re_n),
    .io_out    (io_out),
    .io_oe     (io_oe),
    .io_in     (io_in)
  );

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rb_s1_reg <= 1'b1;
      rb_s2_reg <= 1'b1;
    end else begin
      rb_s1_reg <= ready_busy_output;
      rb_s2_reg <= rb_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // order sequencer
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg     <= S_IDLE;
      step_reg      <= 5'h00;
      last_reg      <= 5'h00;
      code_reg      <= 3'd0;
      lo_reg        <= 12'h000;
      hi_reg        <= 12'h000;
      inv_reg       <= 1'b0;
      mode_reg      <= `NBPU_AM_RESET;
      grp_reg       <= 4'h0;
      grp_ld_reg    <= 1'b0;
      vld_reg       <= 1'b0;
      pld_reg       <= 1'b0;
      started_reg   <= 1'b0;
      done_reg      <= 1'b0;
      refused_reg   <= 1'b0;
      result_reg    <= 8'h00;
      pbp_count_reg <= 5'h00;
    end else begin
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (op_valid) begin
            code_reg <= op_code;
            lo_reg   <= op_lower_block;
            hi_reg   <= op_upper_block;
            inv_reg  <= op_invert;
            grp_reg  <= op_group;
            grp_ld_reg <= op_group_lockdown;
            step_reg <= 5'h00;
            if (op_code == 3'd0)
              mode_reg <= {3'h0, op_ecc_sel, 1'b1, 1'b0,
                           op_otp_lock & op_otp_mode,
                           op_otp_mode};
            case (op_code)
              3'd0: last_reg <= 5'd5;
              3'd1: last_reg <= 5'd7;
              3'd4: last_reg <= 5'd13;
              3'd5: last_reg <= 5'd4;
              default: last_reg <= 5'd0;
            endcase
            // volatile orders pointless once locked down, and the
            // permanent budget is sixteen attempts at most
            if ((vld_reg && (op_code == 3'd1 || op_code == 3'd2 ||
                             op_code == 3'd3)) ||
                (op_code == 3'd4 && (pld_reg ||
                 pbp_count_reg == `NBPU_PBP_MAX))) begin
              refused_reg <= 1'b1;
              done_reg    <= 1'b1;
            end else begin
              if (op_code == 3'd3)
                vld_reg <= 1'b1;
              if (op_code == 3'd4) begin
                pbp_count_reg <= pbp_count_reg + 5'h01;
                if (op_group_lockdown)
                  pld_reg <= 1'b1;
              end
              state_reg <= S_RUN;
            end
          end
        end
        S_RUN: state_reg <= S_WAIT;
        S_WAIT: begin
          if (cyc_done) begin
            if (kind == 2'd3)
              result_reg <= cyc_rdata;
            if (code_reg == 3'd4 && step_reg == 5'd11) begin
              started_reg <= 1'b0;
              state_reg   <= S_POLL;
            end else if (step_reg == last_reg) begin
              done_reg  <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              step_reg  <= step_reg + 5'h01;
              state_reg <= S_RUN;
            end
          end
        end
        S_POLL: begin
          // no reset until the device drops busy, then read status
          if (!rb_s2_reg)
            started_reg <= 1'b1;
          if (rb_s2_reg && started_reg) begin
            step_reg  <= 5'd12;
            state_reg <= S_RUN;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule

//--- hdl/nbpu_host_regs.vh
// constants of the block protection host controller
`ifndef NBPU_HOST_REGS_VH
`define NBPU_HOST_REGS_VH
// command codes
`define NBPU_CMD_SET_FEAT    8'hef
`define NBPU_CMD_RESET       8'hff
`define NBPU_CMD_STATUS      8'h70
`define NBPU_CMD_UNLOCK_LO   8'h23
`define NBPU_CMD_UNLOCK_HI   8'h24
`define NBPU_CMD_LOCK_ALL    8'h2a
`define NBPU_CMD_LOCKDOWN    8'h2c
`define NBPU_CMD_PROT_READ   8'h7a
`define NBPU_CMD_PGM_SETUP   8'h80
`define NBPU_CMD_PGM_CONF    8'h10
`define NBPU_ENTRY0          8'h4c
`define NBPU_ENTRY1          8'h03
`define NBPU_ENTRY2          8'h1d
`define NBPU_ENTRY3          8'h41
// array operation mode feature register
`define NBPU_FEAT_ARRAY_MODE 8'h90
`define NBPU_AM_OTP_MODE     0
`define NBPU_AM_OTP_LOCK     1
`define NBPU_AM_MUST_ONE     3
`define NBPU_AM_ECC_SEL      4
`define NBPU_AM_RESET        8'h08
// fourth address cycle: bit 4 requests the lockdown form
`define NBPU_PBP_LOCKDOWN    4
// status byte of the protection read
`define NBPU_BLS_VLD         0
`define NBPU_BLS_VNLD        1
`define NBPU_BLS_VUNLK       2
`define NBPU_BLS_PUNLK       3
`define NBPU_BLS_PLD         4
// status register bits
`define NBPU_SR_FAIL         0
`define NBPU_SR_READY        6
// most permanent sequences allowed
`define NBPU_PBP_MAX         5'h10
// bus timing: each phase of a bus strobe lasts at least this many ns
`define NBPU_PHASE_NS        50
`define NBPU_CLK_NS          50
`define NBPU_PHASE_CYC ((`NBPU_PHASE_NS+`NBPU_CLK_NS-1)/`NBPU_CLK_NS)
`endif

//--- hdl/nbpu_bus_cycle.v
// one command, address, write or read cycle on the nand bus
`timescale 1ns/1ps
`include "nbpu_host_regs.vh"
module nbpu_bus_cycle (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // request
  input  wire       start,
  input  wire [1:0] kind,
  input  wire [7:0] wdata,
  output wire       done,
  output reg  [7:0] rdata_reg,
  // nand pins
  output reg        cle,
  output reg        ale,
  output reg        we_n,
  output reg        re_n,
  output reg  [7:0] io_out,
  output reg        io_oe,
  input  wire [7:0] io_in
);
  // kind: 0 command, 1 address, 2 data write, 3 data read
  localparam PH = `NBPU_PHASE_CYC;
  reg [1:0] ph_reg;
  reg [3:0] cnt_reg;
  reg [7:0] in_s1_reg;
  reg [7:0] in_s2_reg;

  assign done = (ph_reg == 2'd3);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_s1_reg <= 8'h00;
      in_s2_reg <= 8'h00;
    end else begin
      in_s1_reg <= io_in;
      in_s2_reg <= in_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // setup phase, strobe low phase, release phase, done
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_reg    <= 2'd0;
      cnt_reg   <= 4'h0;
      cle       <= 1'b0;
      ale       <= 1'b0;
      we_n      <= 1'b1;
      re_n      <= 1'b1;
      io_out    <= 8'h00;
      io_oe     <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      case (ph_reg)
        2'd0: begin
          if (start) begin
            cle     <= (kind == 2'd0);
            ale     <= (kind == 2'd1);
            io_out  <= wdata;
            io_oe   <= (kind != 2'd3);
            ph_reg  <= 2'd1;
            cnt_reg <= PH[3:0];
          end
        end
        2'd1: begin
          if (cnt_reg == 4'h0) begin
            we_n    <= (kind == 2'd3);
            re_n    <= (kind != 2'd3);
            ph_reg  <= 2'd2;
            cnt_reg <= PH[3:0] + 4'h2;
          end else
            cnt_reg <= cnt_reg - 4'h1;
        end
        2'd2: begin
          // read sampled late so the two-stage synchroniser has settled
          if (cnt_reg == 4'h0) begin
            if (kind == 2'd3)
              rdata_reg <= in_s2_reg;
            we_n   <= 1'b1;
            re_n   <= 1'b1;
            ph_reg <= 2'd3;
          end else
            cnt_reg <= cnt_reg - 4'h1;
        end
        2'd3: begin
          cle    <= 1'b0;
          ale    <= 1'b0;
          io_oe  <= 1'b0;
          ph_reg <= 2'd0;
        end
        default: ph_reg <= 2'd0;
      endcase
    end
  end
endmodule

//--- bench/nbpu_chk.sv
// assertions on the host controller pins
`timescale 1ns/1ps
module nbpu_chk (
  // clock and reset
  input wire       clk,
  input wire       rst,
  // user side
  input wire       op_valid,
  input wire       op_ready,
  input wire [2:0] op_code,
  input wire       done_reg,
  input wire       refused_reg,
  input wire [4:0] pbp_count_reg,
  // nand pins
  input wire       cle,
  input wire       we_n,
  input wire       re_n,
  input wire       wp_n,
  input wire       protection_enable_input,
  input wire [7:0] io_out,
  input wire       io_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire cw = cle && !we_n;
  wire go4 = op_valid && op_ready && op_code == 3'd4;
  //////////////////////////////
  property p_pe; cw |-> protection_enable_input; endproperty
  a_pe: assert property (p_pe) else $error("enable low");
  property p_ld;
    cw && io_out == 8'h2c |-> wp_n && protection_enable_input;
  endproperty
  a_ld: assert property (p_ld) else $error("lockdown pins");
  property p_lim; go4 && pbp_count_reg == 5'h10 |-> ##[1:2] refused_reg;
  endproperty
  a_lim: assert property (p_lim) else $error("limit passed");
  property p_cnt;
    $changed(pbp_count_reg) |-> pbp_count_reg == $past(pbp_count_reg) + 5'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step");
  property p_wr; !we_n |-> io_oe && re_n; endproperty
  a_wr: assert property (p_wr) else $error("write undriven");
  property p_rd; !re_n |-> !io_oe && !cle; endproperty
  a_rd: assert property (p_rd) else $error("read contended");
  property p_stb; $fell(we_n) |=> !we_n ##[1:3] we_n; endproperty
  a_stb: assert property (p_stb) else $error("strobe width");
  property p_ref; refused_reg |-> done_reg ##1 !done_reg; endproperty
  a_ref: assert property (p_ref) else $error("refusal pulse");
  c_ld: cover property (cw && io_out == 8'h2c);
  c_ref: cover property (refused_reg);
  c_rd: cover property (!re_n);
endmodule

//--- bench/nbpu_dev.sv
// behavioural nand device: protection logic and array mode register
`timescale 1ns/1ps
module nbpu_dev (
  // power-on reset
  input  wire       rst,
  // nand pins
  input  wire       ce_n,
  input  wire       cle,
  input  wire       ale,
  input  wire       we_n,
  input  wire       re_n,
  input  wire       wp_n,
  input  wire       pe,
  input  wire [7:0] io_out,
  output wire [7:0] io_in,
  output reg        rb
);
  reg  [7:0]  am_reg, cmd, grp;
  reg  [31:0] hist;
  reg  [11:0] lo, hi, ba;
  reg  [15:0] pmask;
  reg  [2:0]  n;
  reg         iv, inv, unl, vld, pld, permanent_group_protection, pe_on;
  wire        in_r = ba >= lo && ba <= hi;
  wire        p_on = ba < 12'd64 && pmask[ba[5:2]];
  wire        v_un = !pe_on || (unl && (in_r ^ inv));
  wire [7:0]  st = {3'h0, pld, !p_on, v_un, !vld, vld};
  // fail bit stays clear: the model holds no array to program
  wire [7:0]  rd = (cmd == 8'h7a) ? st : {wp_n, rb, 6'h00};
  event       go;
  // released bus shows the inverse so a stale byte never matches
  assign io_in = re_n ? ~rd : rd;
  initial begin
    rb = 1'b1;
    pmask = 16'h0000;
    pld = 1'b0;
  end
  always @(go) begin
    rb = 1'b0;
    #1000 rb = 1'b1;
  end
  // write protect held low past 100ns relocks until lockdown
  always @(negedge wp_n) begin
    #101;
    if (!wp_n && !vld) unl <= 1'b0;
  end
  //////////////////////////////
  always @(posedge we_n or posedge rst) begin
    if (rst) begin
      am_reg <= 8'h08;
      {unl, vld, permanent_group_protection, n, cmd, hist} <= 46'h0;
      pe_on <= pe;
    end else if (!ce_n && cle) begin
      cmd <= io_out;
      n <= 3'h0;
      hist <= {hist[23:0], io_out};
      // reset code leaves am_reg alone
      if (io_out == 8'hff) permanent_group_protection <= 1'b0;
      if (io_out == 8'h80) permanent_group_protection <= hist == 32'h4c031d41;
      if (io_out == 8'h2a && !vld && pe) unl <= 1'b0;
      if (io_out == 8'h2c && pe && wp_n) vld <= 1'b1;
      if (io_out == 8'h10 && permanent_group_protection && !pld) begin
        pmask[grp[3:0]] <= 1'b1;
        pld <= grp[4];
        -> go;
      end
    end else if (!ce_n) begin
      n <= n + 3'h1;
      if (ale && n == 3'h0) {ba[1:0], iv} <= {io_out[7:6], io_out[0]};
      if (ale && n == 3'h1) ba[9:2] <= io_out;
      if (ale && n == 3'h2) ba[11:10] <= io_out[1:0];
      if (ale && n == 3'h3) grp <= io_out;
      if (ale && n == 3'h2 && !vld && pe) begin
        if (cmd == 8'h23) lo <= {io_out[1:0], ba[9:0]};
        if (cmd == 8'h24) begin
          hi <= {io_out[1:0], ba[9:0]};
          {inv, unl} <= {iv, 1'b1};
        end
      end
      if (!ale && cmd == 8'hef && n == 3'h1)
        am_reg <= io_out | {6'h0, am_reg[1], 1'b0};
    end
  end
endmodule

//--- bench/nbpu_host_tb.sv
// self-checking bench for the block protection host controller
`timescale 1ns/1ps
module nbpu_host_tb;
  reg        clk, rst, op_valid, op_invert, op_group_lockdown, rf;
  reg        op_otp_mode, op_otp_lock, op_ecc_sel;
  reg [2:0]  op_code;
  reg [3:0]  op_group;
  reg [7:0]  am;
  reg [11:0] op_lower_block, op_upper_block;
  wire       op_ready, done_reg, refused_reg, cle, ale, ce_n, we_n, re_n;
  wire       wp_n, pe, io_oe, rb;
  wire [4:0] pbp_count_reg;
  wire [7:0] result_reg, io_out, io_in;
  int        bad_count, tests_run, cyc, i, a, b, lo, hi, inv, unl, vld, pld;
  int        pm[$], bl[$];
  nbpu_host DUT (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
    .op_code(op_code), .op_lower_block(op_lower_block),
    .op_upper_block(op_upper_block), .op_invert(op_invert),
    .op_group(op_group), .op_group_lockdown(op_group_lockdown),
    .op_otp_mode(op_otp_mode), .op_otp_lock(op_otp_lock),
    .op_ecc_sel(op_ecc_sel), .done_reg(done_reg), .refused_reg(refused_reg),
    .result_reg(result_reg), .pbp_count_reg(pbp_count_reg), .cle(cle),
    .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .protection_enable_input(pe), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_in), .ready_busy_output(rb)
  );
  nbpu_dev DEV (
    .rst(rst), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n),
    .wp_n(wp_n), .pe(pe), .io_out(io_out), .io_in(io_in), .rb(rb)
  );
  //////////////////////////////
  function automatic [7:0] exp_st(input int blk);
    int p;
    begin
      p = 0;
      foreach (pm[k]) if (blk < 64 && pm[k] == blk / 4) p = 1;
      exp_st = {3'h0, pld != 0, p == 0,
                unl != 0 && ((blk >= lo && blk <= hi) != (inv != 0)),
                vld == 0, vld != 0};
    end
  endfunction
  task automatic chk_byte(input [7:0] got, input [7:0] exp);
    begin
      tests_run++;
      if (got !== exp) begin
        bad_count++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic chk_bit(input got, input exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // one order, entered and left just after a rising edge; outputs are
  // read settled, never in the time step of the edge that moves them
  task automatic order(input [2:0] c);
    begin
      op_code = c;
      op_valid = 1'b1;
      while (op_ready !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      @(posedge clk);
      #2 op_valid = 1'b0;
      while (done_reg !== 1'b1) begin
        @(posedge clk);
        #2;
      end
      rf = refused_reg;
      // let an edge pass so a following order never re-raises valid
      // in the time step that lowered it
      @(posedge clk);
      #2;
    end
  endtask
  task automatic rd_st(input int blk);
    begin
      op_lower_block = blk[11:0];
      order(3'd5);
      chk_byte(result_reg, exp_st(blk & 4095));
    end
  endtask
  //////////////////////////////
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    {clk, rst, op_valid, op_invert, op_group_lockdown, rf} = 6'b000000;
    {op_otp_mode, op_otp_lock, op_ecc_sel, op_code, op_group} = 10'h0;
    {op_lower_block, op_upper_block} = 24'h0;
    am = 8'h08;
    a = $urandom(61643);
    // raise reset after the tied enable pin has settled, so the
    // device latches a defined level at power on
    #1 rst = 1'b1;
    repeat (16) @(posedge clk);
    #2 rst = 1'b0;
    rd_st(0);
    for (i = 0; i < 8; i++) begin
      {op_otp_mode, op_otp_lock, op_ecc_sel} = i[2:0];
      order(3'd0);
      am = {3'h0, op_ecc_sel, 2'b10, am[1] | (op_otp_lock & op_otp_mode),
            op_otp_mode};
      chk_byte(DEV.am_reg, am);
    end
    order(3'd6);
    chk_byte(DEV.am_reg, am);
    for (i = 0; i < 4; i++) begin
      a = $urandom_range(4095);
      b = $urandom_range(4095);
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      inv = i % 2;
      {op_lower_block, op_upper_block, op_invert} = {lo[11:0], hi[11:0],
                                                     inv[0]};
      order(3'd1);
      chk_bit(rf, 1'b0);
      unl = 1;
      if (i == 3) order(3'd3);
      vld = i == 3;
      bl = '{lo - 1, lo, hi, hi + 1, a};
      foreach (bl[k]) rd_st(bl[k]);
      if (i == 1) begin
        order(3'd2);
        unl = 0;
        rd_st(lo);
      end
    end
    for (i = 1; i < 4; i++) begin
      order(i[2:0]);
      chk_bit(rf, 1'b1);
    end
    rd_st(hi);
    for (i = 0; i < 17; i++) begin
      op_group = i[3:0];
      op_group_lockdown = i == 15;
      order(3'd4);
      chk_bit(rf, i == 16);
      if (i < 16) begin
        pm.push_back(i);
        chk_byte(result_reg, 8'hc0);
        chk_byte({3'h0, pbp_count_reg}, 8'(i + 1));
      end
    end
    pld = 1;
    for (i = 0; i < 4; i++) rd_st($urandom_range(70));
    stop_test;
  end
endmodule
bind nbpu_host nbpu_chk u_chk (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_ready(op_ready),
  .op_code(op_code), .done_reg(done_reg), .refused_reg(refused_reg),
  .pbp_count_reg(pbp_count_reg), .cle(cle), .we_n(we_n), .re_n(re_n),
  .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
  .protection_enable_input(protection_enable_input)
);
